// ===== include/dpcr_cfg.svh
// Offsets, field positions and reset values of the data path configuration registers.
// Assumes an 8-bit register port with 8-bit addresses.
`ifndef DPCR_CFG_SVH
`define DPCR_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DPCR_OFS_DATA_PATH_CTRL  8'h22
`define DPCR_OFS_GP_CTRL         8'h23
`define DPCR_OFS_LINK_STATUS     8'h30

// ----------------------------------------------------------------
// Data path control fields
// ----------------------------------------------------------------
`define DPCR_DPC_LOAD_BLOCK_BIT  7
`define DPCR_DPC_PASS_PIX_BIT    6
`define DPCR_DPC_DE_POL_BIT      5
`define DPCR_DPC_AUD_RGB_DIS_BIT 4
`define DPCR_DPC_CHB_SRC_BIT     3
`define DPCR_DPC_VID18_BIT       2
`define DPCR_DPC_AUD_FRAME_BIT   1
`define DPCR_DPC_CHB_EN_BIT      0
`define DPCR_DPC_REMOTE_MSB      6

// ----------------------------------------------------------------
// General purpose control fields
// ----------------------------------------------------------------
`define DPCR_GPC_CSUM_EN_BIT     7
`define DPCR_GPC_MODE_DONE_BIT   4
`define DPCR_GPC_LOW_FREQ_BIT    3
`define DPCR_GPC_REPEATER_BIT    2
`define DPCR_GPC_BACKWARD_BIT    1
`define DPCR_GPC_CHB_STATUS_BIT  0

// ----------------------------------------------------------------
// Link status fields
// ----------------------------------------------------------------
`define DPCR_LST_CSUM_ERR_BIT    0
`define DPCR_LST_CNT_LSB         4
`define DPCR_LST_CNT_MSB         7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DPCR_RST_DATA_PATH_CTRL  8'h00
`define DPCR_RST_GP_CTRL         8'h10
`define DPCR_RST_LINK_STATUS     8'h00

`endif

// ===== include/dpcr_pkg.sv
// Types shared by the data path configuration block.
// Assumes nothing of its surroundings.
package dpcr_pkg;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        chb;
		logic [23:0] data;
	} dpcr_audio_pkt_t;

	typedef struct packed {
		logic        valid;
		logic [6:0]  fields;
	} dpcr_remote_cfg_t;

	typedef struct packed {
		logic mode_done;
		logic low_freq;
		logic repeater;
		logic backward;
	} dpcr_mode_status_t;

	// ----------------------------------------------------------------
	// Checksum checker states
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		DPCR_CS_IDLE,
		DPCR_CS_LINE
	} dpcr_cs_state_t;

endpackage

// ===== core/dpcr_pin_sync.sv
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to clk; output follows once stages two and three agree.
`timescale 1ns/100ps
module dpcr_pin_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic pin,
	output logic      level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;
	logic level_d;

	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q    <= pin;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule // dpcr_pin_sync

// ===== core/dpcr_line_csum.sv
// Per-line checksum checker for the pixel stream.
// Assumes the checksum byte sits in pix[7:0] on the first cycle after the line's data enable.
`timescale 1ns/100ps
module dpcr_line_csum (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        enable,
	input  wire logic        de_active,
	input  wire logic [23:0] pix,
	output logic             mismatch
);
	dpcr_pkg::dpcr_cs_state_t state_q;
	dpcr_pkg::dpcr_cs_state_t state_d;
	logic [7:0]               sum_q;
	logic [7:0]               sum_d;
	logic                     mismatch_q;
	logic                     mismatch_d;
	logic [7:0]               pix_sum;

	assign pix_sum = pix[23:16] + pix[15:8] + pix[7:0];

	always_comb begin
		state_d    = state_q;
		sum_d      = sum_q;
		mismatch_d = 1'b0;
		unique case (state_q)
			dpcr_pkg::DPCR_CS_IDLE: begin
				if (enable && de_active) begin
					state_d = dpcr_pkg::DPCR_CS_LINE;
					sum_d   = pix_sum;
				end
			end
			dpcr_pkg::DPCR_CS_LINE: begin
				// Disabling mid-line abandons the line rather than flag a partial sum
				if (!enable) begin
					state_d = dpcr_pkg::DPCR_CS_IDLE;
				end else if (de_active) begin
					sum_d = sum_q + pix_sum;
				end else begin
					state_d    = dpcr_pkg::DPCR_CS_IDLE;
					mismatch_d = (pix[7:0] != sum_q);
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q    <= dpcr_pkg::DPCR_CS_IDLE;
			sum_q      <= 8'h00;
			mismatch_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			sum_q      <= sum_d;
			mismatch_q <= mismatch_d;
		end
	end

	assign mismatch = mismatch_q;
endmodule // dpcr_line_csum

// ===== core/dpcr_top.sv
// Data path control and general purpose control registers with the pixel,
// audio and channel B output paths they steer.
// Assumes register port, pixel, audio and remote config inputs are on CLK;
// only the channel B strap pin is asynchronous.
`timescale 1ns/100ps
`include "dpcr_cfg.svh"

// Function
// - Block bit stops remote loads, keeps local values
// - Otherwise bits 6..0 follow remote serializer
// - Pass bit outputs pixels regardless of enable
// - Pass bit suppresses packetized audio on pixel pins, not on channel B pin
// - Bit 5 sets data enable polarity
// - Bit 4 set keeps audio off pixel pins
// - Bit 3 picks channel B enable source
// - Bit 2 selects 18 or 24 bit video
// - Bit 1 selects audio transport method
// - Bit 0 enables channel B output pin when bit 3 set
// - Checksum enable checks byte after each line
// - Mismatches reported in link status register
// - Status bits 4..1 show mode flags, bit 0 channel B enable
module dpcr_top (
	input  wire logic                         CLK,
	input  wire logic                         RESETN,
	// Register port
	input  wire logic [7:0]                   REG_ADDR,
	input  wire logic                         REG_WR,
	input  wire logic [7:0]                   REG_WDATA,
	input  wire logic                         REG_RD,
	output logic      [7:0]                   REG_RDATA,
	output logic                              REG_RVALID,
	// Remote serializer configuration
	input  wire dpcr_pkg::dpcr_remote_cfg_t   REMOTE_CFG,
	// Mode status from the link logic
	input  wire dpcr_pkg::dpcr_mode_status_t  MODE_STATUS,
	// Channel B strap pin
	input  wire logic                         CHB_STRAP_PIN,
	// Pixel input from the deserializer core
	input  wire logic [23:0]                  PIX_IN,
	input  wire logic                         DE_IN,
	// Audio packets from both transports
	input  wire dpcr_pkg::dpcr_audio_pkt_t    AUD_FRAME_PKT,
	input  wire dpcr_pkg::dpcr_audio_pkt_t    AUD_ISLAND_PKT,
	// Outputs
	output logic      [23:0]                  RGB_OUT,
	output logic                              DE_OUT,
	output logic                              AUDIO_CH_B_OUTPUT_PIN,
	output logic                              VIDEO_18BIT,
	output logic                              AUDIO_FRAME_TRANSPORT,
	output logic                              CSUM_ERROR
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]  dpc_q;
	logic [7:0]  dpc_d;
	logic        csum_en_q;
	logic        csum_en_d;
	logic        csum_err_q;
	logic        csum_err_d;
	logic [3:0]  err_cnt_q;
	logic [3:0]  err_cnt_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [23:0] rgb_q;
	logic [23:0] rgb_d;
	logic        de_out_q;
	logic        de_out_d;
	logic        chb_pin_q;
	logic        chb_pin_d;
	logic        csum_flag_q;
	logic        csum_flag_d;

	logic        wr_dpc;
	logic        wr_gpc;
	logic        rd_lst;
	logic        strap_chb;
	logic        de_active;
	logic        pass_pix;
	logic        audio_allowed;
	logic        chb_enable;
	logic        mismatch;
	logic [7:0]  gpc_view;
	logic [7:0]  lst_view;
	logic [23:0] pix_shaped;
	dpcr_pkg::dpcr_audio_pkt_t aud_sel;

	// ----------------------------------------------------------------
	// Reset images
	// ----------------------------------------------------------------
	// Only the enable bit of the general purpose image is stored;
	// its status bits are live inputs with no reset of their own
	localparam logic [7:0] gpc_rst = `DPCR_RST_GP_CTRL;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	dpcr_pin_sync u_strap_sync (
		.clk    (CLK),
		.resetn (RESETN),
		.pin    (CHB_STRAP_PIN),
		.level  (strap_chb)
	);

	// Polarity bit inverts data enable into an active-high qualifier
	assign de_active = DE_IN ^ dpc_q[`DPCR_DPC_DE_POL_BIT];

	dpcr_line_csum u_line_csum (
		.clk       (CLK),
		.resetn    (RESETN),
		.enable    (csum_en_q),
		.de_active (de_active),
		.pix       (PIX_IN),
		.mismatch  (mismatch)
	);

	assign wr_dpc = REG_WR && (REG_ADDR == `DPCR_OFS_DATA_PATH_CTRL);
	assign wr_gpc = REG_WR && (REG_ADDR == `DPCR_OFS_GP_CTRL);
	assign rd_lst = REG_RD && (REG_ADDR == `DPCR_OFS_LINK_STATUS);

	// ----------------------------------------------------------------
	// Data path control register
	// ----------------------------------------------------------------
	// Local write beats a remote load in the same cycle
	always_comb begin
		dpc_d = dpc_q;
		if (wr_dpc) begin
			dpc_d = REG_WDATA;
		end else if (REMOTE_CFG.valid && !dpc_q[`DPCR_DPC_LOAD_BLOCK_BIT]) begin
			dpc_d[`DPCR_DPC_REMOTE_MSB:0] = REMOTE_CFG.fields;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dpc_q <= `DPCR_RST_DATA_PATH_CTRL;
		end else begin
			dpc_q <= dpc_d;
		end
	end

	// ----------------------------------------------------------------
	// General purpose control and link status
	// ----------------------------------------------------------------
	assign chb_enable = dpc_q[`DPCR_DPC_CHB_SRC_BIT] ? dpc_q[`DPCR_DPC_CHB_EN_BIT]
	                                                 : strap_chb;

	// Only the checksum enable is writable; bits 4..0 are live status, bits 6..5 read zero
	always_comb begin
		gpc_view = 8'h00;
		gpc_view[`DPCR_GPC_CSUM_EN_BIT]   = csum_en_q;
		gpc_view[`DPCR_GPC_MODE_DONE_BIT] = MODE_STATUS.mode_done;
		gpc_view[`DPCR_GPC_LOW_FREQ_BIT]  = MODE_STATUS.low_freq;
		gpc_view[`DPCR_GPC_REPEATER_BIT]  = MODE_STATUS.repeater;
		gpc_view[`DPCR_GPC_BACKWARD_BIT]  = MODE_STATUS.backward;
		gpc_view[`DPCR_GPC_CHB_STATUS_BIT] = chb_enable;
	end

	always_comb begin
		lst_view = 8'h00;
		lst_view[`DPCR_LST_CSUM_ERR_BIT] = csum_err_q;
		lst_view[`DPCR_LST_CNT_MSB:`DPCR_LST_CNT_LSB] = err_cnt_q;
	end

	always_comb begin
		csum_en_d  = csum_en_q;
		csum_err_d = csum_err_q;
		err_cnt_d  = err_cnt_q;
		if (wr_gpc) begin
			csum_en_d = REG_WDATA[`DPCR_GPC_CSUM_EN_BIT];
		end
		if (!csum_en_q) begin
			csum_flag_d = 1'b0;
		end else begin
			csum_flag_d = csum_flag_q;
		end
		// Read clears, but a mismatch in the same cycle survives it
		if (rd_lst) begin
			csum_err_d = 1'b0;
			err_cnt_d  = 4'h0;
		end
		if (mismatch) begin
			csum_err_d  = 1'b1;
			csum_flag_d = 1'b1;
			if (rd_lst) begin
				err_cnt_d = 4'h1;
			end else if (err_cnt_q != 4'hf) begin
				err_cnt_d = err_cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			csum_en_q   <= gpc_rst[`DPCR_GPC_CSUM_EN_BIT];
			csum_err_q  <= 1'b0;
			err_cnt_q   <= 4'h0;
			csum_flag_q <= 1'b0;
		end else begin
			csum_en_q   <= csum_en_d;
			csum_err_q  <= csum_err_d;
			err_cnt_q   <= err_cnt_d;
			csum_flag_q <= csum_flag_d;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Unmapped offsets read as zero
	always_comb begin
		rdata_d  = rdata_q;
		rvalid_d = REG_RD;
		if (REG_RD) begin
			unique case (REG_ADDR)
				`DPCR_OFS_DATA_PATH_CTRL: rdata_d = dpc_q;
				`DPCR_OFS_GP_CTRL:        rdata_d = gpc_view;
				`DPCR_OFS_LINK_STATUS:    rdata_d = lst_view;
				default:                  rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// ----------------------------------------------------------------
	// Pixel and audio output path
	// ----------------------------------------------------------------
	assign pass_pix = dpc_q[`DPCR_DPC_PASS_PIX_BIT];
	// Audio may only ride in blanking; pass mode leaves no blanking to use
	assign audio_allowed = !pass_pix
	                       && !dpc_q[`DPCR_DPC_AUD_RGB_DIS_BIT];
	assign aud_sel = dpc_q[`DPCR_DPC_AUD_FRAME_BIT] ? AUD_FRAME_PKT
	                                                : AUD_ISLAND_PKT;

	// 18-bit mode drops the two low bits of each colour
	assign pix_shaped = dpc_q[`DPCR_DPC_VID18_BIT] ? (PIX_IN & 24'hfcfcfc)
	                                               : PIX_IN;

	always_comb begin
		de_out_d = DE_IN;
		rgb_d    = 24'h000000;
		if (pass_pix || de_active) begin
			rgb_d = pix_shaped;
		end else if (audio_allowed && aud_sel.valid) begin
			rgb_d = aud_sel.data;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rgb_q    <= 24'h000000;
			de_out_q <= 1'b0;
		end else begin
			rgb_q    <= rgb_d;
			de_out_q <= de_out_d;
		end
	end

	// ----------------------------------------------------------------
	// Channel B output pin
	// ----------------------------------------------------------------
	// Pin keeps its last bit between packets, so gaps do not glitch it
	always_comb begin
		chb_pin_d = 1'b0;
		if (chb_enable && aud_sel.valid) begin
			chb_pin_d = aud_sel.chb;
		end else if (chb_enable) begin
			chb_pin_d = chb_pin_q;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			chb_pin_q <= 1'b0;
		end else begin
			chb_pin_q <= chb_pin_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign REG_RDATA             = rdata_q;
	assign REG_RVALID            = rvalid_q;
	assign RGB_OUT               = rgb_q;
	assign DE_OUT                = de_out_q;
	assign AUDIO_CH_B_OUTPUT_PIN = chb_pin_q;
	assign VIDEO_18BIT           = dpc_q[`DPCR_DPC_VID18_BIT];
	assign AUDIO_FRAME_TRANSPORT = dpc_q[`DPCR_DPC_AUD_FRAME_BIT];
	assign CSUM_ERROR            = csum_flag_q;

endmodule // dpcr_top

// ===== test/dpcr_remote_ser.sv
// Remote serializer model driving configuration over the forward channel.
// Assumes the bench calls send from its own thread, one send at a time.
`timescale 1ns/100ps
module dpcr_remote_ser (
	input  wire logic                  clk,
	output dpcr_pkg::dpcr_remote_cfg_t cfg
);
	// ----------------------------------------------------------------
	// Sender
	// ----------------------------------------------------------------
	initial cfg = '0;

	// Idle fields show the inverse, so a stale copy is never reused
	task automatic send(input logic [6:0] f, input int unsigned dly);
		repeat (dly) @(negedge clk);
		@(negedge clk);
		cfg = {1'b1, f};
		@(negedge clk);
		cfg = {1'b0, ~f};
	endtask
endmodule // dpcr_remote_ser

// ===== test/dpcr_top_sva.sv
// Assertion checker for the data path and general purpose control registers.
// Assumes it is bound to dpcr_top and sees only that module's ports.
`timescale 1ns/100ps
module dpcr_top_sva (
	input wire logic                       CLK,
	input wire logic                       RESETN,
	input wire logic [7:0]                 REG_ADDR,
	input wire logic                       REG_WR,
	input wire logic [7:0]                 REG_WDATA,
	input wire logic                       REG_RD,
	input wire logic [7:0]                 REG_RDATA,
	input wire logic                       REG_RVALID,
	input wire dpcr_pkg::dpcr_remote_cfg_t REMOTE_CFG,
	input wire dpcr_pkg::dpcr_mode_status_t MODE_STATUS,
	input wire logic [23:0]                PIX_IN,
	input wire logic                       DE_IN,
	input wire dpcr_pkg::dpcr_audio_pkt_t  AUD_FRAME_PKT,
	input wire dpcr_pkg::dpcr_audio_pkt_t  AUD_ISLAND_PKT,
	input wire logic [23:0]                RGB_OUT,
	input wire logic                       DE_OUT,
	input wire logic                       AUDIO_CH_B_OUTPUT_PIN,
	input wire logic                       VIDEO_18BIT,
	input wire logic                       AUDIO_FRAME_TRANSPORT,
	input wire logic                       CSUM_ERROR
);
	// ----------------------------------------------------------------
	// Shadow of the control register
	// ----------------------------------------------------------------
	logic [7:0] dpc_q, dpc_d;
	logic       gpe_q, gpe_d, wr22, act;
	logic [1:0] off_q, off_d;
	logic [23:0] pix_exp;
	dpcr_pkg::dpcr_audio_pkt_t sel;

	always_comb begin
		wr22 = REG_WR && REG_ADDR == 8'h22;
		sel = dpc_q[1] ? AUD_FRAME_PKT : AUD_ISLAND_PKT;
		act = DE_IN ^ dpc_q[5];
		pix_exp = PIX_IN & (dpc_q[2] ? 24'hfcfcfc : 24'hffffff);
		dpc_d = dpc_q;
		if (wr22)
			dpc_d = REG_WDATA;
		else if (REMOTE_CFG.valid && !dpc_q[7])
			dpc_d[6:0] = REMOTE_CFG.fields;
		gpe_d = (REG_WR && REG_ADDR == 8'h23) ? REG_WDATA[7] : gpe_q;
		// Counts edges with checksum off, saturating
		off_d = gpe_q ? 2'h0 : (off_q == 2'h3 ? off_q : off_q + 2'h1);
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dpc_q <= 8'h00;
			gpe_q <= 1'b0;
			off_q <= 2'h0;
		end else begin
			dpc_q <= dpc_d;
			gpe_q <= gpe_d;
			off_q <= off_d;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	property p_mode;
		1'b1 |-> VIDEO_18BIT == dpc_q[2] && AUDIO_FRAME_TRANSPORT == dpc_q[1];
	endproperty
	a_mode: assert property (p_mode) else $error("mode outputs off");
	property p_rd;
		REG_RD && REG_ADDR == 8'h22 |=> REG_RVALID && REG_RDATA == $past(dpc_q);
	endproperty
	a_rd: assert property (p_rd) else $error("control readback wrong");
	property p_pass;
		dpc_q[6] |=> RGB_OUT == $past(pix_exp);
	endproperty
	a_pass: assert property (p_pass) else $error("pixels not passed");
	property p_gate;
		!dpc_q[6] && act |=> RGB_OUT == $past(pix_exp);
	endproperty
	a_gate: assert property (p_gate) else $error("active pixel lost");
	property p_aud;
		!dpc_q[6] && !act && !dpc_q[4] && sel.valid |=> RGB_OUT == $past(sel.data);
	endproperty
	a_aud: assert property (p_aud) else $error("audio not on pins");
	property p_noaud;
		!dpc_q[6] && !act && dpc_q[4] |=> RGB_OUT == 24'h000000;
	endproperty
	a_noaud: assert property (p_noaud) else $error("audio leaked");
	property p_chboff;
		dpc_q[3] && !dpc_q[0] |=> !AUDIO_CH_B_OUTPUT_PIN;
	endproperty
	a_chboff: assert property (p_chboff) else $error("channel B not off");
	property p_chbon;
		dpc_q[3] && dpc_q[0] && sel.valid |=> AUDIO_CH_B_OUTPUT_PIN == $past(sel.chb);
	endproperty
	a_chbon: assert property (p_chbon) else $error("channel B data wrong");
	property p_gprd;
		REG_RD && REG_ADDR == 8'h23 |=>
			REG_RDATA[7:1] == {$past(gpe_q), 2'b00, $past(MODE_STATUS)};
	endproperty
	a_gprd: assert property (p_gprd) else $error("gp readback wrong");
	property p_csoff;
		off_q == 2'h3 |-> !CSUM_ERROR;
	endproperty
	a_csoff: assert property (p_csoff) else $error("error flag stuck");
	property p_deout;
		1'b1 |=> DE_OUT == $past(DE_IN);
	endproperty
	a_deout: assert property (p_deout) else $error("data enable copy wrong");
endmodule // dpcr_top_sva

bind dpcr_top dpcr_top_sva u_sva (
	.CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
	.REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .REMOTE_CFG(REMOTE_CFG), .MODE_STATUS(MODE_STATUS),
	.PIX_IN(PIX_IN), .DE_IN(DE_IN), .AUD_FRAME_PKT(AUD_FRAME_PKT),
	.AUD_ISLAND_PKT(AUD_ISLAND_PKT), .RGB_OUT(RGB_OUT), .DE_OUT(DE_OUT),
	.AUDIO_CH_B_OUTPUT_PIN(AUDIO_CH_B_OUTPUT_PIN), .VIDEO_18BIT(VIDEO_18BIT),
	.AUDIO_FRAME_TRANSPORT(AUDIO_FRAME_TRANSPORT), .CSUM_ERROR(CSUM_ERROR)
);

// ===== test/dpcr_top_tb.sv
// Self-checking bench for the data path configuration registers.
// Assumes the remote serializer model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module dpcr_top_tb;
	logic CLK, RESETN, REG_WR, REG_RD, REG_RVALID, DE_IN, CHB_STRAP_PIN;
	logic AUDIO_CH_B_OUTPUT_PIN, VIDEO_18BIT, AUDIO_FRAME_TRANSPORT, CSUM_ERROR;
	logic DE_OUT;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, d;
	logic [23:0] PIX_IN, RGB_OUT;
	dpcr_pkg::dpcr_remote_cfg_t REMOTE_CFG;
	dpcr_pkg::dpcr_mode_status_t MODE_STATUS;
	dpcr_pkg::dpcr_audio_pkt_t AUD_FRAME_PKT, AUD_ISLAND_PKT;
	logic [7:0] exp_q[$];
	int failures = 0;
	int tests_run = 0;
	int seed = 32'hd2db;

	dpcr_remote_ser rem (.clk(CLK), .cfg(REMOTE_CFG));
	dpcr_top uut (
		.CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.REG_RVALID(REG_RVALID), .REMOTE_CFG(REMOTE_CFG), .MODE_STATUS(MODE_STATUS),
		.CHB_STRAP_PIN(CHB_STRAP_PIN), .PIX_IN(PIX_IN), .DE_IN(DE_IN),
		.AUD_FRAME_PKT(AUD_FRAME_PKT), .AUD_ISLAND_PKT(AUD_ISLAND_PKT),
		.RGB_OUT(RGB_OUT), .DE_OUT(DE_OUT), .AUDIO_CH_B_OUTPUT_PIN(AUDIO_CH_B_OUTPUT_PIN),
		.VIDEO_18BIT(VIDEO_18BIT), .AUDIO_FRAME_TRANSPORT(AUDIO_FRAME_TRANSPORT),
		.CSUM_ERROR(CSUM_ERROR)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] e);
		tests_run++;
		if (seen !== e) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge CLK);
		{REG_ADDR, REG_WDATA, REG_WR} = {a, v, 1'b1};
		@(negedge CLK);
		REG_WR = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge CLK);
		{REG_ADDR, REG_RD} = {a, 1'b1};
		exp_q.push_back(e);
		@(negedge CLK);
		REG_RD = 1'b0;
	endtask

	// One line of two pixels; their byte sum is 8'h66
	task automatic line(input logic [7:0] cs);
		@(negedge CLK);
		{DE_IN, PIX_IN} = {1'b1, 24'h010203};
		@(negedge CLK);
		PIX_IN = 24'h102030;
		@(negedge CLK);
		{DE_IN, PIX_IN} = {1'b0, 16'h0000, cs};
		@(negedge CLK);
		PIX_IN = 24'h000000;
		repeat (4) @(negedge CLK);
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, monitor, watchdog
	// ----------------------------------------------------------------
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	always @(negedge CLK) begin
		if (REG_RVALID === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("mismatch at %0t: unexpected read data", $time);
			end else
				chk(REG_RDATA, exp_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge CLK);
		failures++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{RESETN, REG_WR, REG_RD, DE_IN, CHB_STRAP_PIN} = 5'h00;
		{REG_ADDR, REG_WDATA, PIX_IN} = '0;
		{AUD_FRAME_PKT, AUD_ISLAND_PKT} = '0;
		MODE_STATUS = 4'h8;
		repeat (20) @(negedge CLK);
		RESETN = 1'b1;
		repeat (5) @(negedge CLK);
		rd(8'h22, 8'h00);
		rd(8'h23, 8'h10);
		wr(8'h23, 8'hff);
		rd(8'h23, 8'h90);
		wr(8'h23, 8'h00);
		wr(8'h55, 8'hff);
		rd(8'h55, 8'h00);
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00);
		$display("done: reset values and access kinds");
		rem.send(7'h45, 0);
		rd(8'h22, 8'h45);
		rem.send(7'h3a, 6);
		rd(8'h22, 8'h3a);
		wr(8'h22, 8'h92);
		rem.send(7'h2d, 0);
		rd(8'h22, 8'h92);
		$display("done: remote loading and blocking");
		for (int i = 0; i < 64; i++) begin
			d = 8'($random(seed));
			MODE_STATUS = 4'($random(seed));
			CHB_STRAP_PIN = 1'($random(seed));
			wr(8'h22, d);
			if (d[7])
				rem.send(7'($random(seed)), 0);
			repeat (6) begin
				@(negedge CLK);
				{PIX_IN, DE_IN} = 25'($random(seed));
				AUD_FRAME_PKT = 26'($random(seed));
				AUD_ISLAND_PKT = 26'($random(seed));
			end
			rd(8'h22, d);
			rd(8'h23, {3'b000, MODE_STATUS, d[3] ? d[0] : CHB_STRAP_PIN});
		end
		$display("done: random data path traffic");
		wr(8'h22, 8'h00);
		{DE_IN, PIX_IN, AUD_FRAME_PKT, AUD_ISLAND_PKT} = '0;
		wr(8'h23, 8'h80);
		line(8'h66);
		chk({7'h00, CSUM_ERROR}, 8'h00);
		rd(8'h30, 8'h00);
		line(8'h67);
		chk({7'h00, CSUM_ERROR}, 8'h01);
		rd(8'h30, 8'h11);
		rd(8'h30, 8'h00);
		wr(8'h23, 8'h00);
		repeat (4) @(negedge CLK);
		chk({7'h00, CSUM_ERROR}, 8'h00);
		$display("done: line checksum");
		repeat (3) @(negedge CLK);
		chk(8'(exp_q.size()), 8'h00);
		give_verdict();
	end
endmodule // dpcr_top_tb
